// ==== hdl/host_register_port.sv ====
// host register port: four 16-bit registers reached by an asynchronous host
// assumes host pins are asynchronous to mclk; the pad joins data out/in/enable
`timescale 1ns/1ps
module host_register_port
    import host_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic host_select_n,
    input wire logic [1:0] function_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    output logic host_ready,
    output logic host_irq_n,
    input wire logic irq_out_set,
    output logic run_enable,
    output logic [15:0] pointer_address_low,
    output logic [15:0] pointer_address_high,
    output logic [15:0] host_data_buffer,
    output logic [15:0] host_control,
    output logic access_pulse
);
    `include "host_port_regs.svh"

    // -----------------------------------------------------------------
    // synchronised host pins
    // -----------------------------------------------------------------
    logic sel_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic lds_n_s;
    logic uds_n_s;
    logic [1:0] fsel_s;
    logic [15:0] din_s;

    // every host pin gets two flops before use
    bit_sync #(.RESET_LEVEL(1'b1)) sync_sel (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(host_select_n),
        .sync_out(sel_n_s)
    );
    bit_sync #(.RESET_LEVEL(1'b1)) sync_rd (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(read_strobe_n),
        .sync_out(rd_n_s)
    );
    bit_sync #(.RESET_LEVEL(1'b1)) sync_wr (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(write_strobe_n),
        .sync_out(wr_n_s)
    );
    bit_sync #(.RESET_LEVEL(1'b1)) sync_lds (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(low_byte_select_n),
        .sync_out(lds_n_s)
    );
    bit_sync #(.RESET_LEVEL(1'b1)) sync_uds (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(high_byte_select_n),
        .sync_out(uds_n_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_fsel
            bit_sync #(.RESET_LEVEL(1'b0)) sync_f (
                .mclk(mclk),
                .reset_n(reset_n),
                .async_in(function_select[gi]),
                .sync_out(fsel_s[gi])
            );
        end
        for (gi = 0; gi < 16; gi++) begin : g_din
            bit_sync #(.RESET_LEVEL(1'b0)) sync_d (
                .mclk(mclk),
                .reset_n(reset_n),
                .async_in(host_data_in[gi]),
                .sync_out(din_s[gi])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // reset strap
    // -----------------------------------------------------------------
    logic [1:0] strap_count;

    // select level of the first edge after release, read once it has crossed the synchroniser
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strap_count <= 2'h0;
            run_enable <= 1'b0;
        end else if (strap_count != 2'(`STRAP_SETTLE_CYCLES + 1)) begin
            strap_count <= 2'(strap_count + 2'h1);
            if (strap_count == 2'(`STRAP_SETTLE_CYCLES)) begin
                run_enable <= ~sel_n_s; // low: run at once, high: halt
            end
        end
    end

    // -----------------------------------------------------------------
    // access sequencer
    // -----------------------------------------------------------------
    access_state_type state;
    access_state_type next_state;
    logic strobe_on;
    logic is_read;
    logic is_write;
    logic [1:0] acc_fsel;
    logic [3:0] wait_count;
    logic [3:0] busy_count;
    logic pending;

    // access is live only under select and one strobe
    assign strobe_on = !sel_n_s && (rd_n_s ^ wr_n_s);
    assign is_read = !rd_n_s;
    assign is_write = !wr_n_s;
    assign pending = busy_count != 4'h0;

    // next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (strobe_on) begin
                    // hold off when earlier work pends or control is hit
                    if (pending || fsel_s == `FSEL_CONTROL) begin
                        next_state = ST_WAIT;
                    end else begin
                        next_state = ST_SERVE;
                    end
                end
            end
            ST_WAIT: begin
                if (!strobe_on) begin
                    next_state = ST_IDLE;
                end else if (!pending && wait_count == 4'h0) begin
                    next_state = ST_SERVE;
                end
            end
            ST_SERVE: begin
                next_state = ST_DONE;
            end
            ST_DONE: begin
                // wait for host to end the cycle
                if (!strobe_on) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // state register and captured register index
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            acc_fsel <= `FSEL_PTR_LOW;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && strobe_on) begin
                acc_fsel <= fsel_s;
            end
        end
    end

    // brief control hold-off counter
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wait_count <= 4'h0;
        end else if (state == ST_IDLE && strobe_on) begin
            wait_count <= (fsel_s == `FSEL_CONTROL) ? 4'(`CTRL_WAIT_CYCLES) : 4'h0;
        end else if (wait_count != 4'h0) begin
            wait_count <= wait_count - 4'h1;
        end
    end

    // internal processing time after each served access
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy_count <= 4'h0;
        end else if (state == ST_SERVE) begin
            busy_count <= 4'(`BUSY_CYCLES);
        end else if (busy_count != 4'h0) begin
            busy_count <= busy_count - 4'h1;
        end
    end

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    logic serve_write;
    logic [3:0] low_we;
    logic [3:0] high_we;
    logic [15:0] ctrl_value;
    logic ctrl_clear_irq;

    assign serve_write = state == ST_SERVE && is_write;

    // byte lane and index decode for writes
    always_comb begin
        low_we = 4'h0;
        high_we = 4'h0;
        if (serve_write) begin
            low_we[acc_fsel] = !lds_n_s;
            high_we[acc_fsel] = !uds_n_s;
        end
    end

    byte_lane_reg reg_ptr_low (
        .mclk(mclk),
        .reset_n(reset_n),
        .low_we(low_we[`FSEL_PTR_LOW]),
        .high_we(high_we[`FSEL_PTR_LOW]),
        .write_data(din_s),
        .value(pointer_address_low)
    );
    byte_lane_reg reg_ptr_high (
        .mclk(mclk),
        .reset_n(reset_n),
        .low_we(low_we[`FSEL_PTR_HIGH]),
        .high_we(high_we[`FSEL_PTR_HIGH]),
        .write_data(din_s),
        .value(pointer_address_high)
    );
    byte_lane_reg reg_data (
        .mclk(mclk),
        .reset_n(reset_n),
        .low_we(low_we[`FSEL_DATA]),
        .high_we(high_we[`FSEL_DATA]),
        .write_data(din_s),
        .value(host_data_buffer)
    );
    byte_lane_reg reg_ctrl (
        .mclk(mclk),
        .reset_n(reset_n),
        .low_we(low_we[`FSEL_CONTROL]),
        .high_we(high_we[`FSEL_CONTROL]),
        .write_data(din_s),
        .value(ctrl_value)
    );

    // a host write of zero to the irq bit clears it
    assign ctrl_clear_irq = low_we[`FSEL_CONTROL] && !din_s[`IRQ_OUT_BIT];

    // irq_out_bit: device set wins over host clear
    logic irq_bit;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_bit <= 1'b0;
        end else if (irq_out_set) begin
            irq_bit <= 1'b1;
        end else if (low_we[`FSEL_CONTROL]) begin
            irq_bit <= !ctrl_clear_irq;
        end
    end

    // control view merges the live irq bit
    always_comb begin
        host_control = ctrl_value;
        host_control[`IRQ_OUT_BIT] = irq_bit;
    end

    // -----------------------------------------------------------------
    // host-facing outputs
    // -----------------------------------------------------------------
    logic [15:0] read_mux;

    // register read select
    always_comb begin
        unique case (acc_fsel)
            `FSEL_PTR_LOW: read_mux = pointer_address_low;
            `FSEL_PTR_HIGH: read_mux = pointer_address_high;
            `FSEL_DATA: read_mux = host_data_buffer;
            `FSEL_CONTROL: read_mux = host_control;
        endcase
    end

    // read data latched when served, enable only under select and read
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            host_data_out <= `REG_RESET;
            host_data_oe <= 1'b0;
        end else begin
            if (state == ST_SERVE && is_read) begin
                host_data_out <= read_mux;
            end
            host_data_oe <= !sel_n_s && is_read && (state == ST_DONE || state == ST_SERVE);
        end
    end

    // ready low under select while an access is held off or about to be served
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            host_ready <= 1'b1;
        end else if (sel_n_s) begin
            host_ready <= 1'b1;
        end else begin
            host_ready <= !(next_state == ST_WAIT || (state == ST_IDLE && next_state == ST_SERVE) ||
                next_state == ST_SERVE);
        end
    end

    // interrupt pin follows the irq bit
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            host_irq_n <= 1'b1;
        end else begin
            host_irq_n <= !(irq_bit || irq_out_set);
        end
    end

    // one-cycle pulse when an access is served
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            access_pulse <= 1'b0;
        end else begin
            access_pulse <= state == ST_SERVE;
        end
    end
endmodule

// ==== hdl/host_port_regs.svh ====
// host port constants: register indexes, field positions, timing counts
// assumes inclusion by bare name from the package and the design modules
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ---------------------------------------------------------------------
// register indexes on function_select
// ---------------------------------------------------------------------
`define FSEL_PTR_LOW 2'h0
`define FSEL_PTR_HIGH 2'h1
`define FSEL_DATA 2'h2
`define FSEL_CONTROL 2'h3

// ---------------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------------
`define LOW_BYTE_MSB 7
`define LOW_BYTE_LSB 0
`define HIGH_BYTE_MSB 15
`define HIGH_BYTE_LSB 8
`define IRQ_OUT_BIT 7
`define REG_RESET 16'h0000

// ---------------------------------------------------------------------
// timing: ready hold-off in ns and in mclk cycles (4 ns period)
// ---------------------------------------------------------------------
`define MCLK_PERIOD_NS 4
`define CTRL_WAIT_NS 8
`define CTRL_WAIT_CYCLES ((`CTRL_WAIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define BUSY_NS 32
`define BUSY_CYCLES ((`BUSY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define STRAP_SETTLE_CYCLES 2

`endif

// ==== hdl/host_port_pkg.sv ====
// host port types: access state encoding
// assumes host_port_regs.svh sits on the include path
package host_port_pkg;
    `include "host_port_regs.svh"

    // -----------------------------------------------------------------
    // access sequencer states, one-hot
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_SERVE = 4'h4,
        ST_DONE = 4'h8
    } access_state_type;
endpackage

// ==== hdl/bit_sync.sv ====
// two-flop synchroniser for one asynchronous level
// assumes the input comes from outside the mclk domain
`timescale 1ns/1ps
module bit_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic first_stage;

    // first stage read only by the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            first_stage <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end else begin
            first_stage <= async_in;
            sync_out <= first_stage;
        end
    end
endmodule

// ==== hdl/byte_lane_reg.sv ====
// one 16-bit host register with two byte-lane write enables
// assumes enables are single-cycle pulses from the mclk domain
`timescale 1ns/1ps
module byte_lane_reg (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic low_we,
    input wire logic high_we,
    input wire logic [15:0] write_data,
    output logic [15:0] value
);
    `include "host_port_regs.svh"

    // each byte lane writes independently
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            value <= `REG_RESET;
        end else begin
            if (low_we) begin
                value[`LOW_BYTE_MSB:`LOW_BYTE_LSB] <= write_data[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
            end
            if (high_we) begin
                value[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB] <= write_data[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB];
            end
        end
    end
endmodule

// ==== testbench/host_port_checker.sv ====
// checker: timing relations seen at the host register port pins
// assumes a bind to host_register_port and the single mclk domain
`timescale 1ns/1ps
`include "host_port_regs.svh"
module host_port_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic host_select_n,
    input wire logic [1:0] function_select,
    input wire logic read_strobe_n,
    input wire logic host_data_oe,
    input wire logic host_ready,
    input wire logic host_irq_n,
    input wire logic irq_out_set,
    input wire logic [15:0] host_control,
    input wire logic run_enable,
    input wire logic access_pulse
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // cycles since the last served access, held at its top value
    logic [3:0] since_serve;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            since_serve <= 4'hF;
        end else if (access_pulse) begin
            since_serve <= 4'h0;
        end else if (since_serve != 4'hF) begin
            since_serve <= since_serve + 4'h1;
        end
    end
    // start of a hold-off, and its control-register flavour
    sequence s_hold_start;
        $fell(host_ready);
    endsequence
    sequence s_ctrl_start;
        s_hold_start ##0 function_select == 2'h3;
    endsequence
    property p_idle_ready;
        host_select_n [*3] |-> host_ready;
    endproperty
    property p_fall_cause;
        s_hold_start |-> !$past(host_select_n, 1) && !$past(host_select_n, 2) && !$past(host_select_n, 3);
    endproperty
    property p_ctrl_wait;
        s_ctrl_start |-> !host_ready [*3];
    endproperty
    property p_ready_back;
        !host_ready |-> ##[1:16] host_ready;
    endproperty
    property p_served;
        $rose(host_ready) |-> access_pulse || $past(access_pulse);
    endproperty
    property p_oe_read;
        host_data_oe |-> !$past(read_strobe_n, 1) || !$past(read_strobe_n, 2) || !$past(read_strobe_n, 3)
            || !$past(read_strobe_n, 4);
    endproperty
    property p_irq_set;
        irq_out_set |=> ##[0:2] !host_irq_n;
    endproperty
    property p_irq_clear;
        $rose(host_irq_n) && !$past(irq_out_set) |-> !host_control[7];
    endproperty
    property p_strap;
        $rose(reset_n) |-> ##3 run_enable == !$past(host_select_n, 3);
    endproperty
    property p_busy_hold;
        $fell(host_ready) && since_serve < 4'(`BUSY_CYCLES) |-> !host_ready [*2];
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("ready low while deselected");
    a_fall_cause: assert property (p_fall_cause) else $error("ready fell without synced select");
    a_ctrl_wait: assert property (p_ctrl_wait) else $error("control access hold-off too short");
    a_ready_back: assert property (p_ready_back) else $error("ready stuck low");
    a_served: assert property (p_served) else $error("ready rose with no access served");
    a_oe_read: assert property (p_oe_read) else $error("data bus driven outside a read");
    a_irq_set: assert property (p_irq_set) else $error("irq not raised after set");
    a_irq_clear: assert property (p_irq_clear) else $error("irq dropped while bit set");
    a_strap: assert property (p_strap) else $error("run strap wrong");
    a_busy_hold: assert property (p_busy_hold) else $error("early access not held off");
endmodule

bind host_register_port host_port_checker i_chk (.mclk(mclk), .reset_n(reset_n), .host_select_n(host_select_n),
    .function_select(function_select), .read_strobe_n(read_strobe_n), .host_data_oe(host_data_oe),
    .host_ready(host_ready), .host_irq_n(host_irq_n), .irq_out_set(irq_out_set), .host_control(host_control),
    .run_enable(run_enable), .access_pulse(access_pulse));

// ==== testbench/host_model.sv ====
// host model: asynchronous bus master facing the register port
// assumes the bench calls xfer; pins change at falling mclk edges
`timescale 1ns/1ps
module host_model (
    input wire logic mclk,
    input wire logic [15:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic host_ready,
    output logic host_select_n,
    output logic [1:0] function_select,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic [15:0] host_data_in
);
    logic drv_en = 1'b0;
    logic [15:0] drv_val = 16'h0000;
    logic [15:0] last = 16'h0000;
    // bus level: host, else device, else a pattern changing each cycle
    assign host_data_in = drv_en ? drv_val : (host_data_oe ? host_data_out : ~last);
    always @(posedge mclk) last <= host_data_in;
    initial begin
        {host_select_n, read_strobe_n, write_strobe_n, low_byte_select_n, high_byte_select_n} = 5'h1F;
        function_select = 2'h0;
    end
    // one cycle, held until ready is sampled high
    task automatic xfer(input logic wr, input logic [1:0] fs, input logic [1:0] ln, input logic [15:0] wd,
                        output logic [15:0] rd, output logic late);
        int n;
        n = 0;
        @(negedge mclk);
        host_select_n <= 1'b0;
        function_select <= fs;
        {high_byte_select_n, low_byte_select_n} <= ln;
        drv_en <= wr;
        drv_val <= wd;
        read_strobe_n <= wr;
        write_strobe_n <= !wr;
        while (host_ready === 1'b1 && n < 12) begin
            @(posedge mclk);
            n++;
        end
        while (host_ready !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        rd = host_data_in;
        late = (n >= 40);
        @(negedge mclk);
        {host_select_n, read_strobe_n, write_strobe_n, low_byte_select_n, high_byte_select_n} <= 5'h1F;
        drv_en <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// bench: random and corner host accesses on the register port
// assumes host_model as partner and the bound checker
`timescale 1ns/1ps
`include "host_port_regs.svh"
module tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic irq_out_set = 1'b0;
    logic host_select_n, read_strobe_n, write_strobe_n, low_byte_select_n, high_byte_select_n;
    logic host_data_oe, host_ready, host_irq_n, run_enable, access_pulse, late;
    logic [1:0] function_select;
    logic [15:0] host_data_in, host_data_out, pointer_address_low, pointer_address_high, host_data_buffer;
    logic [15:0] host_control, rd;
    logic [15:0] exp_reg [4];
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;

    host_register_port i_dut (.mclk(mclk), .reset_n(reset_n), .host_select_n(host_select_n),
        .function_select(function_select), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_ready(host_ready), .host_irq_n(host_irq_n), .irq_out_set(irq_out_set), .run_enable(run_enable),
        .pointer_address_low(pointer_address_low), .pointer_address_high(pointer_address_high),
        .host_data_buffer(host_data_buffer), .host_control(host_control), .access_pulse(access_pulse));
    host_model i_host (.mclk(mclk), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_ready(host_ready), .host_select_n(host_select_n), .function_select(function_select),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .host_data_in(host_data_in));

    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        forever #2 mclk = ~mclk;
    end
    // cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] lane_mask(input logic [1:0] ln, input logic [1:0] f);
        lane_mask = {{8{!ln[1]}}, {8{!ln[0]}}};
        if (f == `FSEL_CONTROL) lane_mask = lane_mask & (16'h0001 << `IRQ_OUT_BIT);
    endfunction
    // one access, expected model update, then register and irq views
    task automatic op(input logic w, input logic [1:0] f, input logic [1:0] ln, input logic [15:0] d);
        logic [15:0] m;
        m = lane_mask(ln, f);
        i_host.xfer(w, f, ln, d, rd, late);
        check({15'h0000, late}, 16'h0000);
        if (w) exp_reg[f] = (exp_reg[f] & ~m) | (d & m);
        else check(rd & m, exp_reg[f] & m);
        check(pointer_address_low, exp_reg[0]);
        check(pointer_address_high, exp_reg[1]);
        check(host_data_buffer, exp_reg[2]);
        check({15'h0000, host_irq_n}, {15'h0000, !exp_reg[3][`IRQ_OUT_BIT]});
        check({15'h0000, host_control[`IRQ_OUT_BIT]}, {15'h0000, exp_reg[3][`IRQ_OUT_BIT]});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hA561));
        exp_reg = '{default: `REG_RESET};
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check({15'h0000, run_enable}, 16'h0000);
        check({15'h0000, host_ready}, 16'h0001);
        op(1'b1, 2'h2, 2'b00, 16'h8001);
        op(1'b0, 2'h2, 2'b00, 16'h0000);
        op(1'b1, 2'h0, 2'b10, 16'h12A5);
        op(1'b1, 2'h0, 2'b01, 16'hC300);
        op(1'b0, 2'h0, 2'b00, 16'h0000);
        // device raises the irq bit, host reads it, then clears it
        irq_out_set = 1'b1;
        @(negedge mclk);
        irq_out_set = 1'b0;
        exp_reg[3][`IRQ_OUT_BIT] = 1'b1;
        repeat (3) @(negedge mclk);
        op(1'b0, 2'h3, 2'b00, 16'h0000);
        op(1'b1, 2'h3, 2'b10, 16'h0000);
        repeat (40) begin
            op(1'($urandom_range(0, 1)), 2'($urandom_range(0, 3)), 2'($urandom_range(0, 3)), 16'($urandom));
        end
        // second reset with select low: run at once
        i_host.host_select_n = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check({15'h0000, run_enable}, 16'h0001);
        i_host.host_select_n = 1'b1;
        exp_reg = '{default: `REG_RESET};
        op(1'b0, 2'h1, 2'b00, 16'h0000);
        finish_test();
    end
endmodule
